// *** logic/smpm_power_fsm.sv ***
// Operating state controller of the multi-channel switch monitor.
`timescale 1ns/1ps
// Operation
// - Held in reset state while core supply low.
// - Lockout keeps registers, blocks serial, analog, currents.
// - Leaving lockout, read fuses 50 us, then normal.
// - Fast oscillator off in low power, poll and pin check; slow always; timers derived.
// - Wake pin driven low in normal mode.
// - Normal mode runs all fault detections.
// - Low power entered only by dedicated command.
// - Low power stops fast oscillator, faults ignored.
// - Listed wake sources return device to normal.
// - Pin edge wakes only with I/O supply high.
// - Poll timer opens window, compares inputs to entry.
// - Interrupt timer expiry interrupts and enters normal.
// - Interrupt timer beats coincident poll; poll skipped.
// - Open-at-entry, still-open inputs stop polling early.
// - Battery undervoltage pauses polling without waking.
// - Poll end returns low power unless wake.
// - Comparator-only inputs watched continuously, change wakes.
// - No wake enables: ignore changes, stop poll timer.
// - Threshold decoding inverted between ground and battery switches.
// - Thermal limits ORed; fault cuts wetting current.
// - Undervoltage mid serial word discards word, enters lockout.
// - Interrupt on change, timer, wake, fault, startup.
module smpm_power_fsm #(
   parameter int FUSE_CYCLES = smpm_pkg::FUSE_CYC
) (
   // Clock and power-on reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Analog status, asynchronous
   input wire logic battery_uv,
   input wire logic battery_ov,
   input wire logic io_supply_ok,
   input wire logic thermal_warn,
   input wire logic [3:0] thermal_limit_fault_cells,
   input wire logic [21:0] cmp_above,
   // Pins, asynchronous inputs and open-drain drives
   input wire logic cs_pin_in,
   input wire logic int_pin_in,
   input wire logic int_pin_out,
   input wire logic wake_pin_in,
   output logic int_pin_drv,
   output logic int_pin_oe,
   output logic wake_pin_drv,
   output logic wake_pin_oe,
   // Serial engine, same clock
   input wire logic enter_lp_cmd,
   input wire logic spi_word_active,
   input wire logic spi_err,
   input wire logic hash_err,
   input wire logic int_clr,
   input wire logic fault_clr,
   // Configuration, same clock
   input wire logic [7:0] battery_switch_config,
   input wire logic [21:0] wake_en,
   input wire logic [21:0] cmp_only,
   input wire logic wake_pin_wake_en,
   input wire logic [2:0] int_timer_sel,
   input wire logic [2:0] poll_timer_sel,
   // Control and status
   output smpm_pkg::smpm_state_e op_state,
   output logic spi_enable,
   output logic spi_discard,
   output logic analog_output_mux_enable,
   output logic [21:0] current_en,
   output logic fast_osc_en,
   output logic fault_det_en,
   output logic [4:0] fault_flags,
   output logic thermal_limit_fault,
   output logic wetting_min,
   output logic [21:0] switch_closed,
   output logic [2:0] wake_cause,
   output logic poll_active_window
);
   smpm_tmr_if tif ();
   smpm_pkg::smpm_state_e state_r, state_nxt;
   logic [smpm_pkg::ASYNC_W-1:0] sync1_r, sync2_r;
   logic [2:0] pin_d_r;
   logic [smpm_pkg::DIV_W-1:0] div_cnt_r;
   logic slow_tick_r;
   logic [smpm_pkg::FUSE_W-1:0] fuse_cnt_r;
   logic [15:0] win_cnt_r;
   logic [21:0] ref_closed_r, ref_open_r, poll_sns_r;
   logic [2:0] pend_cause_r, cause_nxt;
   logic spi_en_r, discard_r, analog_output_mux_r, fast_r, fdet_r, thermal_limit_fault_r, wmin_r, int_req_r;
   logic wake_oe_r, int_drv_r, wake_drv_r, poll_win_r;
   logic [21:0] cur_r, closed_r;
   logic [4:0] fault_r;
   logic [2:0] cause_r;
   logic woke;
   localparam logic [smpm_pkg::FUSE_W-1:0] FUSE_W_LAST = smpm_pkg::FUSE_W'(FUSE_CYCLES - 1);
   localparam logic [smpm_pkg::DIV_W-1:0] DIV_LAST = smpm_pkg::DIV_W'(smpm_pkg::SLOW_DIV - 1);
   // The lockout bit resets high, so no false exit from lockout follows reset.
   localparam logic [smpm_pkg::ASYNC_W-1:0] SYNC_RST = smpm_pkg::ASYNC_W'(1'b1) << smpm_pkg::A_UV;

   // Decoded views of the synchronised inputs.
   wire logic uv_s = sync2_r[smpm_pkg::A_UV];
   wire logic io_ok_s = sync2_r[smpm_pkg::A_IOOK];
   wire logic thermal_limit_fault_any = |sync2_r[smpm_pkg::A_THERMAL_LIMIT_FAULT +: smpm_pkg::THERMAL_LIMIT_FAULT_NUM];
   wire logic [2:0] pins_s = {sync2_r[smpm_pkg::A_WAKE], sync2_r[smpm_pkg::A_INT],
                               sync2_r[smpm_pkg::A_CS]};
   wire logic [2:0] pin_fall = pin_d_r & ~pins_s;
   wire logic cs_fall = pin_fall[0];
   wire logic int_fall = pin_fall[1];
   wire logic wake_fall = pin_fall[2] & wake_pin_wake_en;
   wire logic [21:0] above_s = sync2_r[smpm_pkg::A_CMP +: smpm_pkg::CH_NUM];
   wire logic [21:0] bat_vec = {battery_switch_config, {smpm_pkg::GND_NUM{1'b0}}};
   wire logic [21:0] closed_now = ~(above_s ^ bat_vec);
   wire logic [21:0] open_now = ~closed_now;
   wire logic any_wake_en = |wake_en;
   wire logic [21:0] changed = closed_now ^ ref_closed_r;
   wire logic cmp_wake = |(wake_en & cmp_only & changed);
   wire logic poll_wake = |(wake_en & ~cmp_only & poll_sns_r & changed);
   wire logic pin_edge = cs_fall | int_fall | wake_fall;
   wire logic is_normal = (state_r == smpm_pkg::ST_NORMAL);
   wire logic in_lp = (state_r == smpm_pkg::ST_LOWPWR) || (state_r == smpm_pkg::ST_POLL);
   wire logic startup = (state_r == smpm_pkg::ST_RESET) || (state_r == smpm_pkg::ST_UV) ||
                        (state_r == smpm_pkg::ST_FUSE);
   wire logic fuse_done = (fuse_cnt_r == FUSE_W_LAST);
   wire logic win_tick = slow_tick_r && !uv_s;
   wire logic win_end = win_tick && (win_cnt_r == 16'(smpm_pkg::POLL_WIN - 16'h0001));
   wire logic win_mid = win_tick && (win_cnt_r == smpm_pkg::POLL_MID);
   wire logic [4:0] fault_src = {hash_err, spi_err, sync2_r[smpm_pkg::A_TWARN], thermal_limit_fault_any,
                                 sync2_r[smpm_pkg::A_OV]};
   wire logic [4:0] fault_set = is_normal ? fault_src : 5'h00;
   wire logic cos_evt = is_normal && (closed_now != closed_r);
   wire logic int_set = cos_evt || (|fault_set) || woke || startup;

   // Timers count the always-on slow tick; polling stops in undervoltage or with no enables.
   assign tif.slow_tick = slow_tick_r;
   assign tif.restart = (state_r != smpm_pkg::ST_LOWPWR) && (state_r != smpm_pkg::ST_POLL);
   assign tif.int_run = in_lp;
   assign tif.poll_run = (state_r == smpm_pkg::ST_LOWPWR) && any_wake_en && !uv_s;
   assign tif.int_sel = int_timer_sel;
   assign tif.poll_sel = poll_timer_sel;

   smpm_lp_timers u_timers (
      .core_clk (core_clk),
      .sys_rst (sys_rst),
      .tif (tif)
   );

   // Next state and the wake cause that goes with it.
   always_comb begin
      state_nxt = state_r;
      cause_nxt = pend_cause_r;
      woke = 1'b0;
      case (state_r)
         smpm_pkg::ST_RESET: state_nxt = smpm_pkg::ST_UV;
         smpm_pkg::ST_UV: if (!uv_s) state_nxt = smpm_pkg::ST_FUSE;
         smpm_pkg::ST_FUSE: begin
            if (uv_s) state_nxt = smpm_pkg::ST_UV;
            else if (fuse_done) state_nxt = smpm_pkg::ST_NORMAL;
         end
         smpm_pkg::ST_NORMAL: begin
            if (uv_s) state_nxt = smpm_pkg::ST_UV;
            else if (enter_lp_cmd) state_nxt = smpm_pkg::ST_LOWPWR;
         end
         smpm_pkg::ST_LOWPWR, smpm_pkg::ST_POLL: begin
            if (tif.int_expire) begin
               state_nxt = smpm_pkg::ST_NORMAL;
               cause_nxt = smpm_pkg::CAUSE_ITMR;
               woke = 1'b1;
            end else if (cmp_wake || (state_r == smpm_pkg::ST_POLL && win_end && poll_wake)) begin
               state_nxt = smpm_pkg::ST_NORMAL;
               cause_nxt = smpm_pkg::CAUSE_COS;
               woke = 1'b1;
            end else if (pin_edge) begin
               state_nxt = smpm_pkg::ST_IOCHK;
               cause_nxt = cs_fall ? smpm_pkg::CAUSE_CSPIN :
                           int_fall ? smpm_pkg::CAUSE_IPIN : smpm_pkg::CAUSE_WPIN;
            end else if (state_r == smpm_pkg::ST_POLL) begin
               if (win_end) state_nxt = smpm_pkg::ST_LOWPWR;
            end else if (tif.poll_due) begin
               state_nxt = smpm_pkg::ST_POLL;
            end
         end
         smpm_pkg::ST_IOCHK: begin
            state_nxt = io_ok_s ? smpm_pkg::ST_NORMAL : smpm_pkg::ST_LOWPWR;
            woke = io_ok_s;
         end
         default: state_nxt = smpm_pkg::ST_RESET;
      endcase
   end

   // Every asynchronous input passes two flops before anything reads it.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sync1_r <= SYNC_RST;
         sync2_r <= SYNC_RST;
         pin_d_r <= 3'h0;
      end else begin
         sync1_r <= {battery_uv, battery_ov, io_supply_ok, thermal_warn, thermal_limit_fault_cells,
                     wake_pin_in, int_pin_in, cs_pin_in, cmp_above};
         sync2_r <= sync1_r;
         pin_d_r <= pins_s;
      end
   end

   // Slow tick stands in for the always-running low-rate oscillator.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         div_cnt_r <= '0;
         slow_tick_r <= 1'b0;
      end else begin
         div_cnt_r <= (div_cnt_r == DIV_LAST) ? '0 : smpm_pkg::DIV_W'(div_cnt_r + 1'b1);
         slow_tick_r <= (div_cnt_r == DIV_LAST);
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_r <= smpm_pkg::ST_RESET;
         fuse_cnt_r <= '0;
         win_cnt_r <= 16'h0000;
         pend_cause_r <= smpm_pkg::CAUSE_NONE;
      end else begin
         state_r <= state_nxt;
         pend_cause_r <= cause_nxt;
         fuse_cnt_r <= (state_r == smpm_pkg::ST_FUSE) ? smpm_pkg::FUSE_W'(fuse_cnt_r + 1'b1) : '0;
         if (state_r != smpm_pkg::ST_POLL) win_cnt_r <= 16'h0000;
         else if (win_tick) win_cnt_r <= 16'(win_cnt_r + 16'h0001);
      end
   end

   // Input references are taken at low-power entry; the poll senses only channels that need it.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ref_closed_r <= 22'h000000;
         ref_open_r <= 22'h000000;
         poll_sns_r <= 22'h000000;
      end else begin
         if (is_normal && enter_lp_cmd) begin
            ref_closed_r <= closed_now;
            ref_open_r <= open_now;
         end
         if (state_r == smpm_pkg::ST_LOWPWR && state_nxt == smpm_pkg::ST_POLL)
            poll_sns_r <= wake_en & ~cmp_only;
         else if (state_r != smpm_pkg::ST_POLL)
            poll_sns_r <= 22'h000000;
         else if (win_mid)
            poll_sns_r <= poll_sns_r & ~(ref_open_r & open_now);
      end
   end

   // Mode-dependent drives; lockout keeps serial, analog mux, currents and wake pin quiet.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         spi_en_r <= 1'b0;
         discard_r <= 1'b0;
         analog_output_mux_r <= 1'b0;
         cur_r <= 22'h000000;
         fast_r <= 1'b0;
         fdet_r <= 1'b0;
         wake_oe_r <= 1'b0;
         poll_win_r <= 1'b0;
      end else begin
         spi_en_r <= (state_nxt == smpm_pkg::ST_NORMAL);
         discard_r <= is_normal && uv_s && spi_word_active;
         analog_output_mux_r <= (state_nxt == smpm_pkg::ST_NORMAL);
         cur_r <= (state_r == smpm_pkg::ST_NORMAL) ? {smpm_pkg::CH_NUM{1'b1}} :
                  (state_r == smpm_pkg::ST_POLL) ? poll_sns_r : 22'h000000;
         fast_r <= !(in_lp || state_r == smpm_pkg::ST_IOCHK);
         fdet_r <= is_normal;
         wake_oe_r <= (state_nxt == smpm_pkg::ST_NORMAL);
         poll_win_r <= (state_nxt == smpm_pkg::ST_POLL);
      end
   end

   // Status: faults and interrupt request are sticky, and a new event wins over a clear.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         fault_r <= 5'h00;
         thermal_limit_fault_r <= 1'b0;
         wmin_r <= 1'b0;
         closed_r <= 22'h000000;
         cause_r <= smpm_pkg::CAUSE_NONE;
         int_req_r <= 1'b1;
         int_drv_r <= 1'b0;
         wake_drv_r <= 1'b0;
      end else begin
         fault_r <= fault_set | (fault_clr ? 5'h00 : fault_r);
         thermal_limit_fault_r <= is_normal && thermal_limit_fault_any;
         wmin_r <= is_normal && thermal_limit_fault_any;
         if (is_normal) closed_r <= closed_now;
         if (woke) cause_r <= cause_nxt;
         int_req_r <= int_set || (int_req_r && !int_clr);
         int_drv_r <= 1'b0;
         wake_drv_r <= 1'b0;
      end
   end

   // The open-drain pins only ever pull low; the enable carries the level.
   assign int_pin_drv = int_drv_r;
   assign int_pin_oe = int_req_r;
   assign wake_pin_drv = wake_drv_r;
   assign wake_pin_oe = wake_oe_r;
   assign op_state = state_r;
   assign spi_enable = spi_en_r;
   assign spi_discard = discard_r;
   assign analog_output_mux_enable = analog_output_mux_r;
   assign current_en = cur_r;
   assign fast_osc_en = fast_r;
   assign fault_det_en = fdet_r;
   assign fault_flags = fault_r;
   assign thermal_limit_fault = thermal_limit_fault_r;
   assign wetting_min = wmin_r;
   assign switch_closed = closed_r;
   assign wake_cause = cause_r;
   assign poll_active_window = poll_win_r;
endmodule // smpm_power_fsm

// *** logic/smpm_pkg.sv ***
// Shared constants, field positions and state type of the switch monitor power mode controller.
package smpm_pkg;
   // Channel layout: ground-switch channels first, programmable ones above them.
   localparam int CH_NUM = 22;
   localparam int GND_NUM = 14;
   localparam int PRG_NUM = 8;
   localparam int THERMAL_LIMIT_FAULT_NUM = 4;
   localparam int F_NUM = 5;

   // Clock rates and the divider that makes the always-on slow tick.
   localparam int CORE_HZ = 250_000_000;
   localparam int SLOW_HZ = 192_000;
   localparam int SLOW_DIV = (CORE_HZ + SLOW_HZ / 2) / SLOW_HZ;
   localparam int DIV_W = 11;

   // Fuse read time, and its length in core cycles (rounded up).
   localparam int FUSE_US = 50;
   localparam int FUSE_CYC = (FUSE_US * CORE_HZ + 999_999) / 1_000_000;
   localparam int FUSE_W = 14;

   // Low-power timers, in slow ticks.
   localparam int TMR_W = 16;
   localparam logic [15:0] INT_BASE = 16'h00C0;
   localparam logic [15:0] POLL_BASE = 16'h0300;
   localparam logic [15:0] POLL_WIN = 16'h000C;
   localparam logic [15:0] POLL_MID = 16'h0006;
   localparam logic [2:0] SEL_OFF = 3'h0;
   localparam logic [2:0] SEL_ONE = 3'h1;

   // Field positions in the synchronised vector of asynchronous inputs.
   localparam int A_CMP = 0;
   localparam int A_CS = 22;
   localparam int A_INT = 23;
   localparam int A_WAKE = 24;
   localparam int A_THERMAL_LIMIT_FAULT = 25;
   localparam int A_TWARN = 29;
   localparam int A_IOOK = 30;
   localparam int A_OV = 31;
   localparam int A_UV = 32;
   localparam int ASYNC_W = 33;

   // Fault flag positions.
   localparam int F_OV = 0;
   localparam int F_OT = 1;
   localparam int F_TW = 2;
   localparam int F_SPI = 3;
   localparam int F_HASH = 4;

   // Wake cause codes.
   localparam logic [2:0] CAUSE_NONE = 3'h0;
   localparam logic [2:0] CAUSE_COS = 3'h1;
   localparam logic [2:0] CAUSE_ITMR = 3'h2;
   localparam logic [2:0] CAUSE_WPIN = 3'h3;
   localparam logic [2:0] CAUSE_IPIN = 3'h4;
   localparam logic [2:0] CAUSE_CSPIN = 3'h5;

   typedef enum logic [2:0] {
      ST_RESET, ST_UV, ST_FUSE, ST_NORMAL, ST_LOWPWR, ST_POLL, ST_IOCHK
   } smpm_state_e;
endpackage

// *** logic/smpm_tmr_if.sv ***
// Signals between the power mode controller and its low-power timers.
`timescale 1ns/1ps
interface smpm_tmr_if;
   logic slow_tick;
   logic restart;
   logic int_run;
   logic poll_run;
   logic [2:0] int_sel;
   logic [2:0] poll_sel;
   logic int_expire;
   logic poll_due;
   modport fsm (output slow_tick, restart, int_run, poll_run, int_sel, poll_sel,
                input int_expire, poll_due);
   modport tmr (input slow_tick, restart, int_run, poll_run, int_sel, poll_sel,
                output int_expire, poll_due);
endinterface

// *** logic/smpm_lp_timers.sv ***
// Interrupt timer and polling timer of low-power mode, counted in slow ticks.
`timescale 1ns/1ps
module smpm_lp_timers (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Controller side
   smpm_tmr_if.tmr tif
);
   logic [15:0] int_cnt_r;
   logic [15:0] poll_cnt_r;
   logic int_expire_r;
   logic poll_due_r;
   wire logic [15:0] int_last;
   wire logic [15:0] poll_last;
   wire logic int_on;
   wire logic poll_on;

   // A select of n gives a period of the base times two to the n-1.
   assign int_last = 16'((smpm_pkg::INT_BASE << (tif.int_sel - smpm_pkg::SEL_ONE)) - 16'h0001);
   assign poll_last = 16'((smpm_pkg::POLL_BASE << (tif.poll_sel - smpm_pkg::SEL_ONE)) - 16'h0001);
   assign int_on = tif.int_run && (tif.int_sel != smpm_pkg::SEL_OFF);
   assign poll_on = tif.poll_run && (tif.poll_sel != smpm_pkg::SEL_OFF);
   assign tif.int_expire = int_expire_r;
   assign tif.poll_due = poll_due_r;

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         int_cnt_r <= 16'h0000;
         int_expire_r <= 1'b0;
      end else begin
         int_expire_r <= 1'b0;
         if (tif.restart) begin
            int_cnt_r <= 16'h0000;
         end else if (int_on && tif.slow_tick) begin
            int_expire_r <= (int_cnt_r == int_last);
            int_cnt_r <= (int_cnt_r == int_last) ? 16'h0000 : 16'(int_cnt_r + 16'h0001);
         end
      end
   end

   // The poll counter holds its count while stopped, so a paused poll resumes.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         poll_cnt_r <= 16'h0000;
         poll_due_r <= 1'b0;
      end else begin
         poll_due_r <= 1'b0;
         if (tif.restart) begin
            poll_cnt_r <= 16'h0000;
         end else if (poll_on && tif.slow_tick) begin
            poll_due_r <= (poll_cnt_r == poll_last);
            poll_cnt_r <= (poll_cnt_r == poll_last) ? 16'h0000 : 16'(poll_cnt_r + 16'h0001);
         end
      end
   end
endmodule // smpm_lp_timers

// *** verif/smpm_power_fsm_props.sv ***
// Concurrent assertions of the switch monitor power mode controller.
`timescale 1ns/1ps
module smpm_power_fsm_props #(
   parameter int FUSE_CYCLES = smpm_pkg::FUSE_CYC
) (
   // Clock, reset and inputs
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic io_supply_ok,
   input wire logic enter_lp_cmd,
   // Outputs under watch
   input var smpm_pkg::smpm_state_e op_state,
   input wire logic spi_enable,
   input wire logic analog_output_mux_enable,
   input wire logic [21:0] current_en,
   input wire logic fast_osc_en,
   input wire logic fault_det_en,
   input wire logic wake_pin_drv,
   input wire logic wake_pin_oe,
   input wire logic int_pin_oe,
   input wire logic spi_discard,
   input wire logic [2:0] wake_cause,
   input wire logic poll_active_window
);
   wire in_nrm = op_state == smpm_pkg::ST_NORMAL;
   wire in_lp = op_state == smpm_pkg::ST_LOWPWR;
   wire st_uv = op_state == smpm_pkg::ST_UV;
   wire st_fu = op_state == smpm_pkg::ST_FUSE;
   wire st_io = op_state == smpm_pkg::ST_IOCHK;
   wire asleep = in_lp | st_io | (op_state == smpm_pkg::ST_POLL);
   logic [15:0] fuse_cnt_r;
   logic [3:0] io_cnt_r;
   logic io_q_r;
   // The supply counter saturates so a long steady stretch never reads as fresh.
   wire [3:0] io_cnt_nxt = (io_q_r != io_supply_ok) ? 4'h0 : io_cnt_r + {3'h0, ~&io_cnt_r};
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         {fuse_cnt_r, io_cnt_r, io_q_r} <= 21'h000000;
      end else begin
         fuse_cnt_r <= st_fu ? fuse_cnt_r + 16'h0001 : 16'h0000;
         {io_cnt_r, io_q_r} <= {io_cnt_nxt, io_supply_ok};
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   a_uv_lockout: assert property (st_uv && $past(st_uv) |-> !spi_enable && !analog_output_mux_enable
      && current_en == 22'h000000) else $error("lockout leaves outputs active");
   a_fuse_time: assert property ($past(st_fu) && !st_fu |->
      in_nrm && fuse_cnt_r == 16'(FUSE_CYCLES)) else $error("fuse read length wrong");
   a_osc_normal: assert property (in_nrm && $past(in_nrm) |->
      fast_osc_en && fault_det_en) else $error("normal mode lacks oscillator or faults");
   a_lp_quiet: assert property (in_lp && $past(in_lp) |->
      !fast_osc_en && !fault_det_en && !wake_pin_oe) else $error("low power not quiet");
   a_wake_drive: assert property (in_nrm && $past(in_nrm) |->
      wake_pin_oe && !wake_pin_drv) else $error("wake pin not low in normal");
   a_lp_cause: assert property (in_lp && $past(in_nrm) |->
      $past(enter_lp_cmd)) else $error("low power without command");
   a_io_wake: assert property (st_io && io_cnt_r > 4'h5 && io_q_r |=>
      in_nrm) else $error("pin wake with supply up failed");
   a_io_sleep: assert property (st_io && io_cnt_r > 4'h5 && !io_q_r |=>
      in_lp) else $error("pin wake with supply down not refused");
   a_poll_flag: assert property ($stable(op_state) |->
      poll_active_window == (op_state == smpm_pkg::ST_POLL)) else $error("poll flag wrong");
   a_wake_report: assert property (in_nrm && $past(asleep) |-> ##[0:2]
      (int_pin_oe && wake_cause != smpm_pkg::CAUSE_NONE)) else $error("wake not reported");
   a_discard_uv: assert property (spi_discard |-> ##[0:3] st_uv)
      else $error("discarded word without lockout");
   c_lp_entry: cover property (in_lp && $past(in_nrm));
   c_pin_wake: cover property (st_io ##1 in_nrm);
   c_pin_reject: cover property (st_io ##1 in_lp);
   c_fuse_done: cover property (st_fu ##1 in_nrm);
endmodule  // smpm_power_fsm_props
bind smpm_power_fsm smpm_power_fsm_props #(.FUSE_CYCLES(FUSE_CYCLES)) u_props (.*);

// *** verif/smpm_host_model.sv ***
// Host microcontroller side: open-drain pin wiring and wake reply bookkeeping.
`timescale 1ns/1ps
module smpm_host_model (
   // Clock and host requests
   input wire logic core_clk,
   input wire logic cs_req,
   input wire logic int_req,
   input wire logic wake_req,
   // Device drives and pin levels
   input wire logic int_pin_oe,
   input wire logic wake_pin_oe,
   output logic cs_pin_in,
   output logic int_pin_in,
   output logic wake_pin_in,
   output logic discard_reply
);
   // Released open-drain lines return to their pull-up level.
   assign int_pin_in = ~(int_pin_oe | int_req);
   assign wake_pin_in = ~(wake_pin_oe | wake_req);
   assign cs_pin_in = ~cs_req;
   always_ff @(posedge core_clk) begin
      if (cs_req) begin
         discard_reply <= wake_pin_in;
      end
   end
endmodule  // smpm_host_model

// *** verif/test_smpm_power_fsm.sv ***
// Self-checking bench of the switch monitor power mode controller.
`timescale 1ns/1ps
module test_smpm_power_fsm;
   logic core_clk, sys_rst, battery_uv, battery_ov, io_supply_ok, thermal_warn, int_pin_out;
   logic cs_pin_in, int_pin_in, wake_pin_in, int_pin_drv, int_pin_oe, wake_pin_drv;
   logic wake_pin_oe, enter_lp_cmd, spi_word_active, spi_err, hash_err, int_clr, fault_clr;
   logic wake_pin_wake_en, spi_enable, spi_discard, analog_output_mux_enable, fast_osc_en, fault_det_en;
   logic thermal_limit_fault, wetting_min, poll_active_window, cs_req, int_req, wake_req;
   logic discard_reply;
   logic [3:0] thermal_limit_fault_cells;
   logic [7:0] battery_switch_config;
   logic [2:0] int_timer_sel, poll_timer_sel, wake_cause;
   logic [4:0] fault_flags;
   logic [21:0] cmp_above, wake_en, cmp_only, current_en, switch_closed;
   logic [31:0] rng = 32'h00000006;
   logic [31:0] r;
   smpm_pkg::smpm_state_e op_state;
   int failures, n_tests;
   smpm_power_fsm #(.FUSE_CYCLES(8)) uut (.*);
   smpm_host_model host (.*);
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   initial begin
      #100000;
      failures++;
      stop_test();
   end
   function automatic logic [31:0] rnd();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction
   function automatic logic [21:0] exp_closed(logic [21:0] a, logic [7:0] b);
      return {a[21:14] ^ ~b, ~a[13:0]};
   endfunction
   task automatic chk(logic [31:0] got, logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic tick(int n);
      repeat (n) @(negedge core_clk);
   endtask
   task automatic wait_st(smpm_pkg::smpm_state_e s, int n);
      for (int i = 0; i < n && op_state !== s; i++) @(negedge core_clk);
      chk(32'(op_state), 32'(s));
   endtask
   task automatic go_lp();
      enter_lp_cmd = 1'b1;
      tick(1);
      enter_lp_cmd = 1'b0;
      wait_st(smpm_pkg::ST_LOWPWR, 2);
   endtask
   task automatic pin_fall(int k);
      {wake_req, int_req, cs_req} = 3'h1 << k;
      tick(3);
      {wake_req, int_req, cs_req} = 3'h0;
   endtask
   task automatic clr_int();
      int_clr = 1'b1;
      tick(1);
      int_clr = 1'b0;
      tick(1);
   endtask
   task automatic stop_test();
      $display("failures %0d n_tests %0d", failures, n_tests);
      if (failures == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      {sys_rst, battery_uv, io_supply_ok, battery_ov, thermal_warn, int_pin_out} = 6'h38;
      {enter_lp_cmd, spi_word_active, spi_err, hash_err, int_clr, fault_clr} = 6'h00;
      {cs_req, int_req, wake_req, int_timer_sel, poll_timer_sel} = 9'h000;
      {wake_pin_wake_en, thermal_limit_fault_cells, battery_switch_config} = 13'h1000;
      {cmp_above, wake_en, cmp_only} = 66'h0;
      failures = 0;
      n_tests = 0;
      tick(12);
      wait_st(smpm_pkg::ST_RESET, 1);
      chk(32'(int_pin_oe), 32'h1);
      sys_rst = 1'b0;
      enter_lp_cmd = 1'b1;
      tick(20);
      enter_lp_cmd = 1'b0;
      wait_st(smpm_pkg::ST_UV, 1);
      chk(32'({spi_enable, analog_output_mux_enable, current_en}), 32'h0);
      battery_uv = 1'b0;
      wait_st(smpm_pkg::ST_NORMAL, 20);
      tick(2);
      chk(32'({int_pin_oe, wake_pin_oe, wake_pin_drv, fast_osc_en, fault_det_en, current_en}),
          32'h6FFFFFF);
      clr_int();
      for (int i = 0; i < 8; i++) begin
         r = rnd();
         cmp_above = (i == 0) ? 22'h0 : (i == 1) ? 22'h3FFFFF : r[21:0];
         battery_switch_config = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : r[29:22];
         tick(6);
         chk(32'(switch_closed), 32'(exp_closed(cmp_above, battery_switch_config)));
      end
      for (int i = 0; i < 4; i++) begin
         thermal_limit_fault_cells = 4'h1 << i;
         tick(6);
         chk(32'({thermal_limit_fault, wetting_min, fault_flags[1]}), 32'h7);
         thermal_limit_fault_cells = 4'h0;
         {hash_err, spi_err, thermal_warn, battery_ov} = 4'h1 << i;
         tick(6);
         {hash_err, spi_err, thermal_warn, battery_ov} = 4'h0;
         chk(32'({thermal_limit_fault, wetting_min, fault_flags}),
             (i == 0) ? 32'h3 : 32'h2 | (32'h2 << i));
         // Synchronised sources must drain first, or the set overrules the clear.
         tick(3);
         fault_clr = 1'b1;
         tick(1);
         fault_clr = 1'b0;
      end
      clr_int();
      go_lp();
      {battery_ov, spi_err} = 2'h3;
      tick(8);
      {battery_ov, spi_err} = 2'h0;
      for (int k = 0; k < 3; k++) begin
         io_supply_ok = 1'b0;
         tick(8);
         pin_fall(k);
         tick(12);
         wait_st(smpm_pkg::ST_LOWPWR, 1);
         io_supply_ok = 1'b1;
         tick(8);
         pin_fall(k);
         wait_st(smpm_pkg::ST_NORMAL, 12);
         chk(32'({fault_flags, wake_cause}), 32'h5 - 32'(k));
         if (k == 0) chk(32'(discard_reply), 32'h1);
         clr_int();
         if (k < 2) go_lp();
      end
      r = rnd();
      wake_en = 22'h1 << (r % 32'h16);
      cmp_only = 22'h3FFFFF;
      go_lp();
      cmp_above = cmp_above ^ ~wake_en;
      tick(20);
      wait_st(smpm_pkg::ST_LOWPWR, 1);
      cmp_above = cmp_above ^ wake_en;
      wait_st(smpm_pkg::ST_NORMAL, 12);
      chk(32'(wake_cause), 32'(smpm_pkg::CAUSE_COS));
      clr_int();
      spi_word_active = 1'b1;
      battery_uv = 1'b1;
      for (int i = 0; i < 8 && spi_discard !== 1'b1; i++) @(negedge core_clk);
      chk(32'(spi_discard), 32'h1);
      wait_st(smpm_pkg::ST_UV, 4);
      {spi_word_active, battery_uv} = 2'h0;
      wait_st(smpm_pkg::ST_NORMAL, 20);
      stop_test();
   end
endmodule  // test_smpm_power_fsm
